// ---- scis_pkg.sv ----
package scis_pkg;
  // Register byte addresses
  localparam logic [11:0] OFS_LINE = 12'h14C;
  localparam logic [11:0] OFS_CTRL = 12'h150;
  localparam logic [11:0] OFS_MASK = 12'h154;
  localparam logic [11:0] OFS_STAT = 12'h158;
  localparam logic [11:0] OFS_ACR = 12'h15C;
  // Status and mask layout
  localparam int B_PARITY = 5;
  localparam int B_FRAME = 4;
  localparam int B_SYNC = 3;
  localparam int B_CARRIER = 2;
  localparam int B_OVF = 1;
  localparam logic [5:1] STAT_RST = 5'h00;
  localparam logic [5:1] MASK_RST = 5'h1F;
  // Additional configuration layout
  localparam int B_RED_FIFO = 21;
  localparam int B_DIRECT_RTS = 20;
  localparam int B_MSB_FIRST = 19;
  localparam logic [2:0] ACR_RST = 3'h0;
  // Channel control layout
  localparam int B_PAR_EN = 0;
  localparam int B_STAT_BYTE_EN = 1;
  localparam int B_SHOW_MASKED = 2;
  localparam int B_FORCE_RTS = 3;
  localparam int B_RTS_REQ = 4;
  localparam int B_HDLC = 5;
  localparam int B_RXCLK_DPLL = 6;
  localparam int B_TXCLK_DPLL = 7;
  localparam int B_FM_ENC = 8;
  localparam int B_EXT_TRANSP = 9;
  localparam int CTRL_W = 10;
  localparam logic [9:0] CTRL_RST = 10'h000;
  // Line status layout
  localparam int B_CD_LEVEL = 0;
  localparam int B_DPLL_LOCK = 1;
  // Transmit FIFO depths in bytes
  localparam logic [4:0] TXF_FULL = 5'h10 + 5'h02;
  localparam logic [4:0] TXF_RED = 5'h02 + 5'h02;
endpackage : scis_pkg

// ---- scis_chan_irq.sv ----
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module scis_chan_irq #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic rx_char_valid,
  input wire logic rx_parity_bad,
  input wire logic rx_stop_zero,
  input wire logic rx_fifo_full,
  input wire logic dpll_unlock,
  input wire logic carrier_detect,
  input wire logic tx_clk_en,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  output logic rx_enable,
  output logic tx_halt,
  output logic [4:0] tx_fifo_depth,
  output logic rts_out,
  output logic rx_stat_valid,
  output logic [7:0] rx_stat_byte,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte
);

  if (ADDR_W < 9)
  begin : g_chk
    $error("ADDR_W too narrow for the register map");
  end

  logic [5:1] stat_q;
  logic [5:1] stat_d;
  logic [5:1] mask_q;
  logic [2:0] acr_q;
  logic [scis_pkg::CTRL_W-1:0] ctrl_q;
  logic [31:0] rdata_q;
  logic cd_s1_q;
  logic cd_s2_q;
  logic cd_s3_q;
  logic [1:0] cd_fill_q;
  logic unlock_q;
  logic rts_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] rx_byte_q;
  logic rx_byte_vld_q;
  logic [7:0] stat_byte_q;
  logic stat_vld_q;

  wire [11:0] addr12 = 12'(reg_addr);
  wire sel_line = addr12 == scis_pkg::OFS_LINE;
  wire sel_ctrl = addr12 == scis_pkg::OFS_CTRL;
  wire sel_mask = addr12 == scis_pkg::OFS_MASK;
  wire sel_stat = addr12 == scis_pkg::OFS_STAT;
  wire sel_acr = addr12 == scis_pkg::OFS_ACR;

  wire par_en = ctrl_q[scis_pkg::B_PAR_EN];
  wire sbyte_en = ctrl_q[scis_pkg::B_STAT_BYTE_EN];
  wire show_masked = ctrl_q[scis_pkg::B_SHOW_MASKED];
  wire force_rts = ctrl_q[scis_pkg::B_FORCE_RTS];
  wire rts_req = ctrl_q[scis_pkg::B_RTS_REQ];
  wire hdlc = ctrl_q[scis_pkg::B_HDLC];
  wire rxclk_dpll = ctrl_q[scis_pkg::B_RXCLK_DPLL];
  wire txclk_dpll = ctrl_q[scis_pkg::B_TXCLK_DPLL];
  wire fm_enc = ctrl_q[scis_pkg::B_FM_ENC];
  wire ext_transp = ctrl_q[scis_pkg::B_EXT_TRANSP];
  wire red_fifo = acr_q[2];
  wire direct_rts = acr_q[1];
  wire msb_first = acr_q[0];

  // Async error flags are only set outside HDLC mode
  wire par_evt = rx_char_valid & par_en & rx_parity_bad & ~hdlc;
  wire frm_evt = rx_char_valid & rx_stop_zero & ~hdlc;
  wire dpll_used = rxclk_dpll & fm_enc;
  wire sync_evt = dpll_used & dpll_unlock & ~unlock_q;
  // Reads the third stage, never the first
  // Gated until the chain has filled, so a pin idling high gives no false edge after reset
  wire cd_evt = (cd_s2_q ^ cd_s3_q) & (cd_fill_q == 2'h3);
  wire ovf_evt = rx_char_valid & rx_fifo_full;

  wire [5:1] evt = {par_evt, frm_evt, sync_evt, cd_evt, ovf_evt};
  wire [5:1] clr = (reg_wr & sel_stat) ? reg_wdata[5:1] : 5'h00;

  // Set wins over a simultaneous clear
  always_comb
  begin
    stat_d = (stat_q & ~clr) | evt;
  end

  wire [5:1] pending = stat_q & ~mask_q;
  // Flags left over from async mode stay hidden in status reads while HDLC mode is on, yet still raise irq
  wire [5:1] mode_keep = hdlc ? 5'h07 : 5'h1F;
  wire [5:1] stat_vis = (show_masked ? stat_q : pending) & mode_keep;
  wire [31:0] stat_rd = {26'h0, stat_vis, 1'b0};
  wire [31:0] mask_rd = {26'h0, mask_q, 1'b0};
  wire [31:0] acr_rd = {10'h000, acr_q, 19'h00000};
  wire [31:0] ctrl_rd = {22'h000000, ctrl_q};
  wire [31:0] line_rd = {30'h0, ~dpll_unlock, cd_s2_q};

  wire [31:0] rd_mux = sel_stat ? stat_rd :
                       sel_mask ? mask_rd :
                       sel_acr ? acr_rd :
                       sel_ctrl ? ctrl_rd :
                       sel_line ? line_rd : 32'h0000_0000;

  assign reg_rdata = rdata_q;
  assign irq = |pending;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stat_q <= scis_pkg::STAT_RST;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      stat_q <= stat_d;
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mask_q <= scis_pkg::MASK_RST;
      acr_q <= scis_pkg::ACR_RST;
      ctrl_q <= scis_pkg::CTRL_RST;
    end
    else if (reg_wr)
    begin
      if (sel_mask)
        mask_q <= reg_wdata[5:1];
      if (sel_acr)
        acr_q <= reg_wdata[scis_pkg::B_RED_FIFO:scis_pkg::B_MSB_FIRST];
      if (sel_ctrl)
        ctrl_q <= reg_wdata[scis_pkg::CTRL_W-1:0];
    end
  end

  // Carrier detect is a pin: two stages before use, third for the edge
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cd_s1_q <= 1'b0;
      cd_s2_q <= 1'b0;
      cd_s3_q <= 1'b0;
      cd_fill_q <= 2'h0;
      unlock_q <= 1'b0;
    end
    else
    begin
      if (cd_fill_q != 2'h3)
        cd_fill_q <= cd_fill_q + 2'h1;
      cd_s1_q <= carrier_detect;
      cd_s2_q <= cd_s1_q;
      cd_s3_q <= cd_s2_q;
      unlock_q <= dpll_unlock & dpll_used;
    end
  end

  // Reception with the receive DPLL and FM encoding on, and DPLL-clocked transmission, stop while lock is lost
  assign rx_enable = ~(dpll_used & dpll_unlock);
  assign tx_halt = dpll_unlock & txclk_dpll;
  assign tx_fifo_depth = red_fifo ? scis_pkg::TXF_RED : scis_pkg::TXF_FULL;

  // The regular path only moves on a transmit clock enable
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      rts_q <= 1'b0;
    else if (tx_clk_en)
      rts_q <= rts_req | force_rts;
  end

  assign rts_out = direct_rts ? force_rts : rts_q;

  // Status byte beside each character
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stat_byte_q <= 8'h00;
      stat_vld_q <= 1'b0;
    end
    else
    begin
      stat_vld_q <= rx_char_valid & sbyte_en;
      if (rx_char_valid & sbyte_en)
        stat_byte_q <= {2'h0, par_evt, frm_evt, 3'h0, rx_fifo_full};
    end
  end

  assign rx_stat_valid = stat_vld_q;
  assign rx_stat_byte = stat_byte_q;

  // Transparent byte assembly; bit placement chosen by the order bit
  wire take_bit = ext_transp & rx_enable & rx_bit_valid;
  wire [7:0] shift_d = msb_first ? {shift_q[6:0], rx_bit} : {rx_bit, shift_q[7:1]};

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      rx_byte_q <= 8'h00;
      rx_byte_vld_q <= 1'b0;
    end
    else
    begin
      rx_byte_vld_q <= take_bit & (bit_cnt_q == 3'h7);
      if (!ext_transp)
        bit_cnt_q <= 3'h0;
      else if (take_bit)
      begin
        shift_q <= shift_d;
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7)
          rx_byte_q <= shift_d;
      end
    end
  end

  assign rx_byte_valid = rx_byte_vld_q;
  assign rx_byte = rx_byte_q;

  a_parity_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rx_char_valid && par_en && rx_parity_bad && !hdlc |=> stat_q[scis_pkg::B_PARITY])
    else $error("parity flag not set");
  a_parity_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !par_en && !stat_q[scis_pkg::B_PARITY] && !($past(par_en)) |=> !stat_q[scis_pkg::B_PARITY])
    else $error("parity flag set while parity off");
  a_frame_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rx_char_valid && rx_stop_zero && !hdlc |=> stat_q[scis_pkg::B_FRAME])
    else $error("framing flag not set");
  a_sync_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
    dpll_used && $rose(dpll_unlock) |=> stat_q[scis_pkg::B_SYNC])
    else $error("sync lost flag not set");
  a_rx_blocked: assert property (@(posedge ref_clk) disable iff (!rst_b)
    dpll_used && dpll_unlock |-> !rx_enable && (tx_halt == txclk_dpll))
    else $error("reception not stopped on lost lock");
  a_carrier_edge: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $changed(carrier_detect) ##3 1'b1 |-> stat_q[scis_pkg::B_CARRIER] || $past(clr[scis_pkg::B_CARRIER]))
    else $error("carrier change not flagged");
  a_ovf_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rx_char_valid && rx_fifo_full |=> stat_q[scis_pkg::B_OVF])
    else $error("overflow flag not set");
  a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(reg_rd) && $past(sel_stat) |-> reg_rdata[0] == 1'b0 && reg_rdata[31:6] == 26'h0)
    else $error("reserved status bits not zero");
  a_w1c_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_wr && sel_stat && evt == 5'h00 |=> stat_q == ($past(stat_q) & ~$past(reg_wdata[5:1])))
    else $error("write one clear wrong");
  a_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ovf_evt && clr[scis_pkg::B_OVF] |=> stat_q[scis_pkg::B_OVF])
    else $error("event lost under clear");
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_b)
    irq == |(stat_q & ~mask_q))
    else $error("interrupt level wrong");
  a_direct_rts: assert property (@(posedge ref_clk) disable iff (!rst_b)
    direct_rts |-> rts_out == force_rts)
    else $error("direct rts wrong");
  a_rts_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !direct_rts && !tx_clk_en && !$past(direct_rts) |=> $stable(rts_out))
    else $error("rts moved without tx clock");
  a_fifo_depth: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tx_fifo_depth == (red_fifo ? 5'h04 : 5'h12))
    else $error("tx fifo depth wrong");
  a_show_masked: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_rd && sel_stat && show_masked |=> reg_rdata[5:1] == $past(stat_q & mode_keep))
    else $error("masked status hidden");
  a_hidden_masked: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_rd && sel_stat && !show_masked |=> reg_rdata[5:1] == $past(stat_q & ~mask_q & mode_keep))
    else $error("masked flag shown");
  a_parity_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !par_en |-> !par_evt)
    else $error("parity event while parity off");
  a_hdlc_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    hdlc |-> !par_evt && !frm_evt)
    else $error("async error event in hdlc mode");
  a_hdlc_hidden: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_rd && sel_stat && hdlc |=> reg_rdata[5:4] == 2'h0)
    else $error("hdlc reserved bits not zero");
  a_sbyte_par: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rx_char_valid && sbyte_en |=> rx_stat_valid && rx_stat_byte[5] == $past(par_en && rx_parity_bad && !hdlc))
    else $error("status byte parity wrong");
  a_sbyte_frm: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rx_char_valid && sbyte_en |=> rx_stat_byte[4] == $past(rx_stop_zero && !hdlc))
    else $error("status byte framing wrong");
  a_sbyte_ovf: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rx_char_valid && sbyte_en |=> rx_stat_byte[0] == $past(rx_fifo_full))
    else $error("status byte overflow wrong");
  a_sbyte_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(rx_char_valid && sbyte_en) |=> !rx_stat_valid)
    else $error("status byte valid without character");
  a_sync_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(rxclk_dpll && fm_enc) |-> !sync_evt)
    else $error("sync event without dpll use");
  a_rx_free: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(dpll_used && dpll_unlock) |-> rx_enable)
    else $error("reception blocked while locked");
  a_tx_free: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !dpll_unlock |-> !tx_halt)
    else $error("transmission halted while locked");
  a_take_locked: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !rx_enable |=> $stable(shift_q))
    else $error("bit taken while reception blocked");
  a_frame_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !stat_q[scis_pkg::B_FRAME] && !(rx_char_valid && rx_stop_zero) |=> !stat_q[scis_pkg::B_FRAME])
    else $error("framing flag set without event");
  a_carrier_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !stat_q[scis_pkg::B_CARRIER] && !cd_evt |=> !stat_q[scis_pkg::B_CARRIER])
    else $error("carrier flag set without edge");
  a_ovf_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !stat_q[scis_pkg::B_OVF] && !(rx_char_valid && rx_fifo_full) |=> !stat_q[scis_pkg::B_OVF])
    else $error("overflow flag set without event");
  a_w1c_keep: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_wr && sel_stat |=> ($past(stat_q) & ~$past(reg_wdata[5:1]) & ~stat_q) == 5'h00)
    else $error("unwritten flag cleared");
  a_flag_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(reg_wr && sel_stat) |=> ($past(stat_q) & ~stat_q) == 5'h00)
    else $error("flag dropped without clear");
  a_mask_rsvd: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(reg_rd) && $past(sel_mask) |-> reg_rdata[0] == 1'b0 && reg_rdata[31:6] == 26'h0)
    else $error("mask reserved bits not zero");
  a_irq_masked: assert property (@(posedge ref_clk) disable iff (!rst_b)
    mask_q == 5'h1F |-> !irq)
    else $error("interrupt despite full mask");
  a_acr_rsvd: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(reg_rd) && $past(sel_acr) |-> reg_rdata[31:22] == 10'h000 && reg_rdata[18:0] == 19'h00000)
    else $error("config reserved bits not zero");
  a_rts_reg: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !direct_rts && tx_clk_en |=> direct_rts || rts_out == $past(rts_req || force_rts))
    else $error("regular rts not updated");
  a_byte_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rx_byte_valid |=> !rx_byte_valid)
    else $error("byte valid too long");
  a_bitcnt_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !ext_transp |=> bit_cnt_q == 3'h0)
    else $error("bit counter not cleared");

  c_parity_irq: cover property (@(posedge ref_clk) disable iff (!rst_b) par_evt ##1 irq);
  c_clear_race: cover property (@(posedge ref_clk) disable iff (!rst_b) |(evt & clr));
  c_byte_done: cover property (@(posedge ref_clk) disable iff (!rst_b) rx_byte_valid && msb_first);
  c_lock_loss: cover property (@(posedge ref_clk) disable iff (!rst_b) sync_evt ##1 tx_halt);
  c_hdlc_hide: cover property (@(posedge ref_clk) disable iff (!rst_b) reg_rd && sel_stat && hdlc && |stat_q[5:4]);

endmodule : scis_chan_irq

// ---- scis_host.sv ----
`timescale 1ns/1ps
// Host software on the register port; never two strobes in one cycle
module scis_host (
  input wire logic ref_clk,
  output logic [11:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  initial
  begin
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // Stale data inverted so a late capture shows up
    reg_wdata <= ~d;
    #1;
  endtask : wr
  // Ones drop only the flags they hit
  task automatic clr(input logic [31:0] d);
    wr(scis_pkg::OFS_STAT, d);
  endtask : clr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : scis_host

// ---- tb_serial_channel_irq_status_config.sv ----
`timescale 1ns/1ps
module tb_serial_channel_irq_status_config;
  localparam logic [11:0] ST = scis_pkg::OFS_STAT;
  localparam logic [11:0] MK = scis_pkg::OFS_MASK;
  localparam logic [11:0] CT = scis_pkg::OFS_CTRL;
  localparam logic [11:0] LN = scis_pkg::OFS_LINE;
  localparam logic [11:0] AC = scis_pkg::OFS_ACR;
  localparam logic [7:0] PAT = 8'hB2;
  logic ref_clk, rst_b, rx_char_valid, rx_parity_bad, rx_stop_zero, rx_fifo_full;
  logic dpll_unlock, carrier_detect, tx_clk_en, rx_bit_valid, rx_bit;
  logic reg_wr, reg_rd, irq, rx_enable, tx_halt, rts_out, rx_stat_valid, rx_byte_valid;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [4:0] tx_fifo_depth;
  logic [7:0] rx_stat_byte, rx_byte;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  scis_host u_scis_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  scis_chan_irq u_scis_chan_irq (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .rx_char_valid(rx_char_valid), .rx_parity_bad(rx_parity_bad), .rx_stop_zero(rx_stop_zero),
    .rx_fifo_full(rx_fifo_full), .dpll_unlock(dpll_unlock), .carrier_detect(carrier_detect),
    .tx_clk_en(tx_clk_en), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_enable(rx_enable),
    .tx_halt(tx_halt), .tx_fifo_depth(tx_fifo_depth), .rts_out(rts_out),
    .rx_stat_valid(rx_stat_valid), .rx_stat_byte(rx_stat_byte), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  // Ceiling well above the roughly 150 cycles the tests need
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      stop_test;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic ev(input logic p, input logic s, input logic f);
    @(posedge ref_clk);
    rx_char_valid <= 1'b1;
    rx_parity_bad <= p;
    rx_stop_zero <= s;
    rx_fifo_full <= f;
    @(posedge ref_clk);
    rx_char_valid <= 1'b0;
    #1;
  endtask : ev
  task automatic t_reset;
    u_scis_host.rd(ST, d); chk(d, 32'h0);
    u_scis_host.rd(AC, d); chk(d, 32'h0);
    u_scis_host.rd(12'h160, d); chk(d, 32'h0);
    chk(32'(irq), 32'h0);
    chk(32'(tx_fifo_depth), 32'h12);
    chk(32'(rts_out), 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_events;
    u_scis_host.wr(MK, 32'h0);
    u_scis_host.wr(CT, 32'h3);
    ev(1'b1, 1'b1, 1'b1);
    chk(32'(rx_stat_byte), 32'h31);
    chk(32'(rx_stat_valid), 32'h1);
    u_scis_host.rd(ST, d); chk(d, 32'h32);
    chk(32'(irq), 32'h1);
    u_scis_host.clr(32'h20);
    u_scis_host.rd(ST, d); chk(d, 32'h12);
    fork
      u_scis_host.clr(32'h32);
      ev(1'b1, 1'b0, 1'b0);
    join
    u_scis_host.rd(ST, d); chk(d, 32'h20);
    $display("test events done");
  endtask : t_events
  task automatic t_mask;
    u_scis_host.wr(MK, 32'h3E);
    chk(32'(irq), 32'h0);
    u_scis_host.rd(ST, d); chk(d, 32'h0);
    u_scis_host.wr(CT, 32'h7);
    u_scis_host.rd(ST, d); chk(d, 32'h20);
    u_scis_host.wr(MK, 32'h1E);
    chk(32'(irq), 32'h1);
    u_scis_host.clr(32'h3E);
    u_scis_host.wr(MK, 32'h0);
    u_scis_host.wr(CT, 32'h1);
    ev(1'b1, 1'b1, 1'b0);
    u_scis_host.wr(CT, 32'h21);
    u_scis_host.rd(ST, d); chk(d, 32'h0);
    u_scis_host.clr(32'h30);
    ev(1'b1, 1'b1, 1'b0);
    u_scis_host.rd(ST, d); chk(d, 32'h0);
    $display("test mask done");
  endtask : t_mask
  task automatic t_sync;
    u_scis_host.wr(CT, 32'h1C0);
    @(posedge ref_clk);
    dpll_unlock <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(32'({rx_enable, tx_halt}), 32'h1);
    u_scis_host.rd(LN, d); chk(d & 32'h2, 32'h0);
    u_scis_host.rd(ST, d); chk(d, 32'h8);
    @(posedge ref_clk);
    dpll_unlock <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(32'(rx_enable), 32'h1);
    u_scis_host.clr(32'h8);
    u_scis_host.wr(CT, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge ref_clk);
      carrier_detect <= ~carrier_detect;
      repeat (5) @(posedge ref_clk);
      u_scis_host.rd(ST, d); chk(d, 32'h4);
      u_scis_host.clr(32'h4);
    end
    $display("test sync done");
  endtask : t_sync
  task automatic t_rts;
    u_scis_host.wr(CT, 32'h10);
    chk(32'(rts_out), 32'h0);
    @(posedge ref_clk);
    tx_clk_en <= 1'b1;
    @(posedge ref_clk);
    tx_clk_en <= 1'b0;
    #1;
    chk(32'(rts_out), 32'h1);
    // Force level goes in before the direct mode is switched on
    u_scis_host.wr(CT, 32'h8);
    u_scis_host.wr(AC, 32'h0010_0000);
    chk(32'(rts_out), 32'h1);
    u_scis_host.wr(CT, 32'h0);
    chk(32'(rts_out), 32'h0);
    u_scis_host.wr(AC, 32'h0020_0000);
    chk(32'(tx_fifo_depth), 32'h4);
    u_scis_host.rd(AC, d); chk(d, 32'h0020_0000);
    $display("test rts done");
  endtask : t_rts
  task automatic t_order;
    int k;
    for (int m = 0; m < 2; m++)
    begin
      u_scis_host.wr(AC, (m == 1) ? 32'h0008_0000 : 32'h0);
      u_scis_host.wr(CT, 32'h200);
      for (int i = 0; i < 8; i++)
      begin
        @(posedge ref_clk);
        rx_bit_valid <= 1'b1;
        rx_bit <= PAT[i];
      end
      @(posedge ref_clk);
      rx_bit_valid <= 1'b0;
      #1;
      k = 0;
      while (rx_byte_valid !== 1'b1 && k < 4)
      begin
        @(posedge ref_clk);
        #1;
        k++;
      end
      chk(32'(rx_byte_valid), 32'h1);
      chk(32'(rx_byte), (m == 1) ? 32'h4D : 32'hB2);
      u_scis_host.wr(CT, 32'h0);
    end
    $display("test order done");
  endtask : t_order
  initial
  begin
    {rx_char_valid, rx_parity_bad, rx_stop_zero, rx_fifo_full} = 4'h0;
    {dpll_unlock, carrier_detect, tx_clk_en, rx_bit_valid, rx_bit} = 5'h00;
    rst_b = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset;
    t_events;
    t_mask;
    t_sync;
    t_rts;
    t_order;
    stop_test;
  end
endmodule : tb_serial_channel_irq_status_config
